/* File: tb/asr_host.sv */
// ==========================================================
// host serial port, burst master, clock idle low
module asr_host (
  // clock
  input  wire logic clk,
  // link to the readout
  input  wire logic sdo,
  output logic      sclk,
  output logic      cs_n,
  output logic      rd_n,
  output logic      chain
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    sclk  = 1'b0;
    cs_n  = 1'b1;
    rd_n  = 1'b1;
    chain = 1'b1;
  end

  // 80 ns period, sample just before each fall; upstream bit changes on the fall
  task automatic read(input int n, input logic [15:0] up, output logic [31:0] rx);
    logic [15:0] u;
    u  = up;
    rx = '0;
    @(posedge clk);
    cs_n  <= 1'b0;
    rd_n  <= 1'b0;
    chain <= u[15];
    repeat (6) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      sclk <= 1'b1;
      repeat (3) @(posedge clk);
      @(negedge clk);
      rx = {rx[30:0], sdo};
      @(posedge clk);
      sclk  <= 1'b0;
      u     = u << 1;
      chain <= u[15];
      repeat (3) @(posedge clk);
    end
    cs_n  <= 1'b1;
    rd_n  <= 1'b1;
    chain <= 1'b1;
    @(posedge clk);
  endtask : read
endmodule : asr_host

/* File: tb/asr_serial_readout_tb.sv */
// ==========================================================
// readout bench
module asr_serial_readout_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst_n, sclk, cs_n, rd_n, cnv_n, chain, pd;
  logic        ext, ser, code, rdc, busy, sdo, oe_n, ovr;
  logic [15:0] res;
  logic [31:0] rx;
  int          n_fail, samples_checked, n_ovr, len;

  asr_serial_readout u_asr_serial_readout (
    .clk(clk), .rst_n(rst_n), .sclk_in(sclk), .cs_n(cs_n), .rd_n(rd_n),
    .convert_start_n(cnv_n), .read_mode_or_chain_in(chain), .power_down_in(pd),
    .clock_source_select(ext), .serial_parallel_select(ser),
    .output_coding_select(code), .read_during_conv_sel(rdc), .core_result(res),
    .busy(busy), .serial_result_out(sdo), .serial_result_oe_n(oe_n),
    .read_overrun_pulse(ovr)
  );
  asr_host u_asr_host (.clk(clk), .sdo(sdo), .sclk(sclk), .cs_n(cs_n), .rd_n(rd_n), .chain(chain));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (ovr === 1'b1) n_ovr <= n_ovr + 1;
  end

  // ==========================================================
  // helpers
  task automatic test_done();
    if (n_fail == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one start pulse; optional second start and power down mid-run
  task automatic convert(input logic [15:0] r, input bit again, output int len);
    @(posedge clk);
    res   <= r;
    cnv_n <= 1'b0;
    repeat (3) @(posedge clk);
    cnv_n <= 1'b1;
    len = 0;
    for (int i = 0; i < 8 && busy !== 1'b1; i++) @(negedge clk);
    if (again) fork
      begin
        repeat (30) @(posedge clk);
        cnv_n <= 1'b0;
        pd    <= 1'b1;
        repeat (3) @(posedge clk);
        cnv_n <= 1'b1;
        pd    <= 1'b0;
      end
    join_none
    while (busy === 1'b1 && len < 500) begin
      len++;
      @(negedge clk);
    end
    repeat (2) @(negedge clk);
    @(posedge clk);
  endtask : convert

  task automatic oe_check(input logic exp);
    logic [31:0] d;
    fork
      u_asr_host.read(8, 16'h0000, d);
      begin
        repeat (20) @(negedge clk);
        check("oe_n_busy", 32'(oe_n), 32'(exp));
      end
    join
    repeat (4) @(negedge clk);
    check("oe_n_idle", 32'(oe_n), 32'h0000_0001);
    @(posedge clk);
  endtask : oe_check

  // ==========================================================
  // tests
  initial begin
    rst_n = 1'b0;
    cnv_n = 1'b1;
    pd    = 1'b0;
    ext   = 1'b1;
    ser   = 1'b1;
    code  = 1'b1;
    rdc   = 1'b0;
    res   = 16'h0000;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check("oe_n_rst", 32'(oe_n), 32'h0000_0001);
    check("busy_rst", 32'(busy), 32'h0000_0000);
    repeat (4) @(posedge clk);
    convert(16'hA5C3, 1'b1, len);
    check("busy_len", len, asr_pkg::CONV_CYCLES);
    u_asr_host.read(16, 16'h0000, rx);
    check("read_after", rx[15:0], 16'hA5C3);
    oe_check(1'b0);
    code <= 1'b0;
    convert(16'h1234, 1'b0, len);
    u_asr_host.read(16, 16'h0000, rx);
    check("twos", rx[15:0], 16'h9234);
    code <= 1'b1;
    convert(16'h8001, 1'b0, len);
    u_asr_host.read(32, 16'h5A0F, rx);
    check("chain", rx, 32'h8001_5A0F);
    u_asr_host.read(4, 16'h0000, rx);
    convert(16'h0F0F, 1'b0, len);
    check("ovr_after", n_ovr, 32'h0000_0000);
    rdc <= 1'b1;
    fork
      u_asr_host.read(16, 16'h0000, rx);
      begin
        repeat (40) @(posedge clk);
        convert(16'h7E81, 1'b0, len);
      end
    join
    check("read_during", rx[15:0], 16'h0F0F);
    check("ovr_none", n_ovr, 32'h0000_0000);
    u_asr_host.read(4, 16'h0000, rx);
    convert(16'h0000, 1'b0, len);
    check("ovr_short", n_ovr, 32'h0000_0001);
    pd    <= 1'b1;
    cnv_n <= 1'b0;
    repeat (8) @(negedge clk);
    check("pd_block", 32'(busy), 32'h0000_0000);
    @(posedge clk);
    cnv_n <= 1'b1;
    pd    <= 1'b0;
    ser <= 1'b0;
    oe_check(1'b1);
    ser <= 1'b1;
    ext <= 1'b0;
    oe_check(1'b1);
    test_done();
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    test_done();
  end
endmodule : asr_serial_readout_tb

/* File: verilog/asr_pkg.sv */
// ==========================================================
// serial readout constants
package asr_pkg;
  localparam int unsigned CLK_HZ         = 100_000_000;
  localparam int unsigned RES_BITS       = 16;
  // fastest shift clock the readout is built for
  localparam int unsigned SCLK_MAX_HZ    = 40_000_000;
  // conversion time of the core, plain default
  localparam int unsigned CONV_TIME_NS   = 1000;
  localparam int unsigned CONV_CYCLES    = (CONV_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [7:0]  CONV_LAST      = 8'(CONV_CYCLES - 1);
  localparam logic [4:0]  BITS_FULL      = 5'h10;
  localparam logic [15:0] RESULT_RST     = 16'h0000;
  localparam logic [15:0] MSB_FLIP       = 16'h8000;

  // synchroniser lane positions
  localparam int unsigned SY_SCLK  = 0;
  localparam int unsigned SY_CS_N  = 1;
  localparam int unsigned SY_RD_N  = 2;
  localparam int unsigned SY_CNV_N = 3;
  localparam int unsigned SY_CHAIN = 4;
  localparam int unsigned SY_PD    = 5;
  localparam int unsigned SY_EXT   = 6;
  localparam int unsigned SY_SER   = 7;
  localparam int unsigned SY_CODE  = 8;
  localparam int unsigned SY_RDC   = 9;
  localparam int unsigned SY_W     = 10;
  // reset level of each lane: select, read and start pins idle high
  localparam logic [9:0]  SY_RST   = 10'h00e;

  typedef enum logic [1:0] {
    ASR_IDLE = 2'b01,
    ASR_CONV = 2'b10
  } asr_state_e;
endpackage : asr_pkg

/* File: verilog/asr_serial_readout.sv */
// Function
// - clock select high takes the shift clock from the external pin.
// - shift clock gated by chip select; data shifts only with select and read low.
// - free-running or burst clock accepted, idle high or idle low.
// - read-after mode: after busy falls the new result reads with select and read low.
// - result leaves msb first, sixteen pulses, each bit held across both edges.
// - read-after mode supports shift clocks up to 40 MHz; host stays below.
// - chain input serves as upstream serial input only in read-after mode.
// - chain input sampled on the edge opposite the data change edge.
// - after own lsb the upstream msb follows on the next shift clock fall.
// - read-during mode outputs the previous result while converting.
// - read-during mode: unfinished read at conversion end pulses the overrun output.
// - a read may start after one conversion and finish during the next.
// - serial path works only with serial select high.
// - select and read combined; output released whenever either is high.
// - a conversion started by convert start cannot be restarted or aborted.
// - coding select picks straight binary or twos complement.
module asr_serial_readout (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // host pins
  input  wire logic        sclk_in,
  input  wire logic        cs_n,
  input  wire logic        rd_n,
  input  wire logic        convert_start_n,
  input  wire logic        read_mode_or_chain_in,
  input  wire logic        power_down_in,
  // configuration pins
  input  wire logic        clock_source_select,
  input  wire logic        serial_parallel_select,
  input  wire logic        output_coding_select,
  input  wire logic        read_during_conv_sel,
  // converter core
  input  wire logic [15:0] core_result,
  // outputs
  output logic             busy,
  output logic             serial_result_out,
  output logic             serial_result_oe_n,
  output logic             read_overrun_pulse
);
  // ==========================================================
  // pin synchronisation
  logic [asr_pkg::SY_W-1:0] pin_raw;
  logic [asr_pkg::SY_W-1:0] pin_s;

  assign pin_raw = {read_during_conv_sel, output_coding_select, serial_parallel_select,
                    clock_source_select, power_down_in, read_mode_or_chain_in,
                    convert_start_n, rd_n, cs_n, sclk_in};

  asr_sync #(
    .W       (asr_pkg::SY_W),
    .RST_VAL (asr_pkg::SY_RST)
  ) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .din   (pin_raw),
    .dout  (pin_s)
  );

  // ==========================================================
  // edge detection
  logic sclk_d_r;
  logic sclk_d_nxt;
  logic cnv_d_r;
  logic cnv_d_nxt;
  logic sclk_rise;
  logic sclk_fall;
  logic start_req;
  logic serial_on;
  logic shift_en;
  logic rdc_mode;

  assign sclk_d_nxt = pin_s[asr_pkg::SY_SCLK];
  assign cnv_d_nxt  = pin_s[asr_pkg::SY_CNV_N];
  // either idle level works: only transitions count
  assign sclk_rise  = pin_s[asr_pkg::SY_SCLK] & ~sclk_d_r;
  assign sclk_fall  = ~pin_s[asr_pkg::SY_SCLK] & sclk_d_r;
  assign start_req  = cnv_d_r & ~pin_s[asr_pkg::SY_CNV_N];
  assign serial_on  = pin_s[asr_pkg::SY_SER] & pin_s[asr_pkg::SY_EXT];
  assign shift_en   = serial_on & ~pin_s[asr_pkg::SY_CS_N] & ~pin_s[asr_pkg::SY_RD_N];
  assign rdc_mode   = pin_s[asr_pkg::SY_RDC];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_d_r <= 1'b0;
      cnv_d_r  <= 1'b1;
    end else begin
      sclk_d_r <= sclk_d_nxt;
      cnv_d_r  <= cnv_d_nxt;
    end
  end

  // ==========================================================
  // conversion sequencing
  asr_pkg::asr_state_e state_r;
  asr_pkg::asr_state_e state_nxt;
  logic [7:0]          timer_r;
  logic [7:0]          timer_nxt;
  logic                busy_nxt;
  logic                conv_done;

  always_comb begin
    state_nxt = state_r;
    timer_nxt = timer_r;
    conv_done = 1'b0;
    unique case (state_r)
      asr_pkg::ASR_IDLE: begin
        if (start_req && !pin_s[asr_pkg::SY_PD]) begin
          state_nxt = asr_pkg::ASR_CONV;
          timer_nxt = asr_pkg::CONV_LAST;
        end
      end
      asr_pkg::ASR_CONV: begin
        // start and power-down are ignored until the end
        if (timer_r == 8'h00) begin
          state_nxt = asr_pkg::ASR_IDLE;
          conv_done = 1'b1;
        end else begin
          timer_nxt = timer_r - 8'h01;
        end
      end
      default: begin
        state_nxt = asr_pkg::ASR_IDLE;
      end
    endcase
    busy_nxt = (state_nxt == asr_pkg::ASR_CONV);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= asr_pkg::ASR_IDLE;
      timer_r <= 8'h00;
      busy    <= 1'b0;
    end else begin
      state_r <= state_nxt;
      timer_r <= timer_nxt;
      busy    <= busy_nxt;
    end
  end

  // ==========================================================
  // result shifter
  logic [15:0] shift_r;
  logic [15:0] shift_nxt;
  logic [15:0] coded;
  logic [4:0]  cnt_r;
  logic [4:0]  cnt_nxt;
  logic        chain_r;
  logic        chain_nxt;
  logic        oe_n_nxt;
  logic        sdo_nxt;
  logic        ovr_nxt;

  always_comb begin
    // select high gives straight binary, low flips the msb
    coded = pin_s[asr_pkg::SY_CODE] ? core_result : (core_result ^ asr_pkg::MSB_FLIP);
    shift_nxt = shift_r;
    cnt_nxt   = cnt_r;
    chain_nxt = chain_r;
    if (conv_done) begin
      shift_nxt = coded;
      cnt_nxt   = 5'h00;
    end else if (shift_en && sclk_fall) begin
      // data moves on the fall: msb stands until the first fall
      // previous result keeps shifting across a new conversion
      shift_nxt = {shift_r[14:0], chain_r};
      if (cnt_r != asr_pkg::BITS_FULL) begin
        cnt_nxt = cnt_r + 5'h01;
      end
    end
    if (rdc_mode) begin
      chain_nxt = 1'b0;
    end else if (shift_en && sclk_rise) begin
      // upstream msb already stands before the first rise
      chain_nxt = pin_s[asr_pkg::SY_CHAIN];
    end
    ovr_nxt  = conv_done && rdc_mode && (cnt_r != 5'h00) && (cnt_r != asr_pkg::BITS_FULL);
    oe_n_nxt = ~shift_en;
    sdo_nxt  = shift_nxt[15];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_r            <= asr_pkg::RESULT_RST;
      cnt_r              <= 5'h00;
      chain_r            <= 1'b0;
      serial_result_out  <= 1'b0;
      serial_result_oe_n <= 1'b1;
      read_overrun_pulse <= 1'b0;
    end else begin
      shift_r            <= shift_nxt;
      cnt_r              <= cnt_nxt;
      chain_r            <= chain_nxt;
      serial_result_out  <= sdo_nxt;
      serial_result_oe_n <= oe_n_nxt;
      read_overrun_pulse <= ovr_nxt;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_load_on_done: assert property (conv_done |=> shift_r == $past(coded))
    else $error("result not loaded at conversion end");
  a_msb_first: assert property (shift_en && sclk_fall && !conv_done |=> serial_result_out == $past(shift_r[14]))
    else $error("serial bit order wrong");
  a_bit_held: assert property (!sclk_fall && !conv_done |=> $stable(shift_r))
    else $error("bit changed without falling edge");
  a_release_out: assert property ((pin_s[asr_pkg::SY_CS_N] || pin_s[asr_pkg::SY_RD_N]) |=> serial_result_oe_n)
    else $error("output driven while deselected");
  a_parallel_off: assert property (!pin_s[asr_pkg::SY_SER] |=> serial_result_oe_n)
    else $error("serial output active in parallel mode");
  a_int_clock: assert property (!pin_s[asr_pkg::SY_EXT] && !conv_done |=> $stable(shift_r))
    else $error("shifting without external clock select");
  a_chain_rise: assert property (shift_en && sclk_rise && !rdc_mode |=> chain_r == $past(pin_s[asr_pkg::SY_CHAIN]))
    else $error("chain input not taken on rising edge");
  a_chain_pass: assert property (shift_en && sclk_fall && !conv_done |=> shift_r[0] == $past(chain_r))
    else $error("upstream bit not passed through");
  a_overrun_hit: assert property (conv_done && rdc_mode && cnt_r != 5'h00 && cnt_r != 5'h10
                                  |=> read_overrun_pulse ##1 !read_overrun_pulse)
    else $error("overrun pulse missing or too long");
  a_no_abort: assert property (start_req && state_r == asr_pkg::ASR_IDLE && !pin_s[asr_pkg::SY_PD]
                               |=> busy [*8])
    else $error("conversion cut short");
  a_coding: assert property (conv_done && !pin_s[asr_pkg::SY_CODE] |=> shift_r[15] != $past(core_result[15]))
    else $error("twos complement coding wrong");

  c_overrun: cover property (read_overrun_pulse);
  c_full_read: cover property (shift_en && sclk_fall && cnt_r == 5'h0f);
  c_chain_bit: cover property (shift_en && sclk_fall && cnt_r == 5'h10 && !rdc_mode);
  c_conv_end: cover property (conv_done);
endmodule : asr_serial_readout

/* File: verilog/asr_sync.sv */
// ==========================================================
// two-flop synchroniser, one lane per pin
module asr_sync #(
  parameter int unsigned         W       = 1,
  parameter logic [W-1:0]        RST_VAL = '0
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // pins and their synchronised copies
  input  wire logic [W-1:0]      din,
  output logic      [W-1:0]      dout
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_lane
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_r[g] <= RST_VAL[g];
          sync_r[g] <= RST_VAL[g];
        end else begin
          meta_r[g] <= din[g];
          sync_r[g] <= meta_r[g];
        end
      end
    end
  endgenerate

  assign dout = sync_r;
endmodule : asr_sync
